// [core/load_extend.sv]
// Load data widening to a full register word
`timescale 1ns/1ps
module load_extend (
  input wire logic [lsu_pkg::WORD_W-1:0] raw_data,
  input wire lsu_pkg::size_e size,
  output logic [lsu_pkg::WORD_W-1:0] ext_data
);
  import lsu_pkg::*;

  // Memory side returns the item right-justified in the word
  always_comb begin
    case (size)
      size_byte: ext_data = {24'h000000, raw_data[7:0]};
      size_half: ext_data = {16'h0000, raw_data[15:0]};
      signed_byte_size: ext_data = {{24{raw_data[7]}}, raw_data[7:0]};
      signed_halfword_size: ext_data = {{16{raw_data[15]}}, raw_data[15:0]};
      default: ext_data = raw_data;
    endcase
  end
endmodule // load_extend

// [core/load_store_address_unit.sv]
// Load/store sequencer: address forming, transfer beats, writeback and branch
// Summary of operation
// - Register offset address: base plus shifted offset
// - Unsigned loads zero-extend, signed loads sign-extend
// - Word load to PC branches, bit zero cleared
// - Load/store never alters condition flags
// - Unprivileged variant presents unprivileged accesses
// - From unprivileged code, variant acts normally
// - Unprivileged offset zero to 255, added
// - PC-relative ranges: 4095 single, 1020 pair
// - Multiple transfers move one word per register
// - Increment-after: upward, lowest register first
// - Decrement-before: downward, highest register first
// - Writeback stores final transfer address in base
// - No mode suffix means increment-after
// - Stack aliases map to increment/decrement forms
// - Multiple load with PC branches, aligned
`timescale 1ns/1ps
module load_store_address_unit (
  input wire logic clock,
  input wire logic rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire lsu_pkg::lsu_op_e cmd_op,
  input wire lsu_pkg::addr_form_e cmd_form,
  input wire lsu_pkg::addr_mode_e cmd_mode,
  input wire lsu_pkg::size_e cmd_size,
  input wire logic cmd_writeback,
  input wire logic cmd_privileged,
  input wire logic [lsu_pkg::IDX_W-1:0] cmd_base_idx,
  input wire logic [lsu_pkg::WORD_W-1:0] cmd_base_value,
  input wire logic [lsu_pkg::WORD_W-1:0] cmd_offset_value,
  input wire logic [1:0] cmd_shift,
  input wire logic signed [lsu_pkg::IMM_W-1:0] cmd_imm,
  input wire logic [lsu_pkg::WORD_W-1:0] cmd_pc_value,
  input wire logic [lsu_pkg::IDX_W-1:0] cmd_rt,
  input wire logic [lsu_pkg::IDX_W-1:0] cmd_rt2,
  input wire logic [lsu_pkg::NUM_REGS-1:0] cmd_list,
  output logic cmd_error,
  output logic [lsu_pkg::IDX_W-1:0] reg_rd_idx,
  input wire logic [lsu_pkg::WORD_W-1:0] reg_rd_data,
  output logic mem_req,
  input wire logic mem_ready,
  output logic [lsu_pkg::WORD_W-1:0] mem_addr,
  output logic mem_write,
  output lsu_pkg::size_e mem_size,
  output logic mem_unpriv,
  output logic [lsu_pkg::WORD_W-1:0] mem_wdata,
  input wire logic [lsu_pkg::WORD_W-1:0] mem_rdata,
  output logic rf_we,
  output logic [lsu_pkg::IDX_W-1:0] rf_idx,
  output logic [lsu_pkg::WORD_W-1:0] rf_data,
  output logic branch_valid,
  output logic [lsu_pkg::WORD_W-1:0] branch_target,
  output logic flags_we,
  output logic done
);
  import lsu_pkg::*;

  typedef enum logic [1:0] {st_idle, st_issue, st_wait, st_base} state_e;

  // Picks the next register of a list in transfer order
  function automatic logic [IDX_W-1:0] pick_reg(input logic [NUM_REGS-1:0] list, input logic down);
    logic [IDX_W-1:0] idx;
    idx = '0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (down && list[i]) idx = IDX_W'(i);
      if (!down && list[NUM_REGS-1-i]) idx = IDX_W'(NUM_REGS-1-i);
    end
    return idx;
  endfunction

  // Returns {load, multiple, pair, down}; aliases fold onto base forms
  function automatic logic [3:0] decode_op(input lsu_op_e op, input addr_mode_e mode);
    logic db;
    db = (mode == decrement_before);
    case (op)
      load_single: decode_op = 4'b1000;
      store_single: decode_op = 4'b0000;
      load_pair: decode_op = 4'b1010;
      load_multiple: decode_op = {3'b110, db};
      store_multiple: decode_op = {3'b010, db};
      load_multiple_full_descending_alias: decode_op = 4'b1100;
      load_multiple_empty_ascending_alias: decode_op = 4'b1101;
      store_multiple_empty_ascending_alias: decode_op = 4'b0100;
      store_multiple_full_descending_alias: decode_op = 4'b0101;
      default: decode_op = 4'b0000;
    endcase
  endfunction

  state_e state_ff;
  logic load_ff, multi_ff, pair_ff, down_ff, wb_ff, beat_ff, unpriv_ff;
  size_e size_ff;
  logic [NUM_REGS-1:0] list_ff;
  logic [IDX_W-1:0] rt_ff, rt2_ff, base_idx_ff, cur_ff;
  logic [WORD_W-1:0] addr_ff, last_addr_ff;
  logic [3:0] dec;
  logic [WORD_W-1:0] start_addr, ext_data, nxt_addr;
  logic bad_offset, cmd_fire, mem_fire, more;
  logic [NUM_REGS-1:0] nxt_list;
  logic [IDX_W-1:0] cur_idx;

  assign dec = decode_op(cmd_op, cmd_mode);
  assign cmd_ready = (state_ff == st_idle);
  assign cmd_fire = cmd_valid && cmd_ready && !bad_offset;
  assign mem_fire = mem_req && mem_ready;
  assign flags_we = 1'b0;

  // Sums are taken at 32 bits so they wrap silently
  always_comb begin
    start_addr = cmd_base_value;
    if (!dec[2] && !dec[1]) begin
      case (cmd_form)
        form_register_offset: start_addr = cmd_base_value + (cmd_offset_value << cmd_shift);
        form_unprivileged: start_addr = cmd_base_value + {24'h000000, cmd_imm[UNPRIV_IMM_W-1:0]};
        default: start_addr = cmd_pc_value + {{19{cmd_imm[IMM_W-1]}}, cmd_imm};
      endcase
    end else if (dec[1]) begin
      start_addr = cmd_pc_value + {{19{cmd_imm[IMM_W-1]}}, cmd_imm};
    end
  end

  // Pair and PC-relative offsets outside the documented ranges are refused, not executed
  always_comb begin
    bad_offset = 1'b0;
    if (dec[1])
      bad_offset = (cmd_imm > PAIR_MAX) || (cmd_imm < -PAIR_MAX) || (cmd_imm[1:0] != 2'b00);
    else if (!dec[2] && cmd_form == form_pc_relative)
      bad_offset = (cmd_imm < -PCREL_MAX);
  end

  assign cur_idx = multi_ff ? pick_reg(list_ff, down_ff) : (beat_ff ? rt2_ff : rt_ff);
  assign reg_rd_idx = cur_idx;
  assign nxt_list = list_ff & ~(16'h0001 << cur_ff);
  assign nxt_addr = down_ff ? addr_ff - WORD_STEP : addr_ff + WORD_STEP;
  assign more = multi_ff ? (nxt_list != RESET_LIST) : (pair_ff && !beat_ff);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= st_idle;
      load_ff <= 1'b0;
      multi_ff <= 1'b0;
      pair_ff <= 1'b0;
      down_ff <= 1'b0;
      wb_ff <= 1'b0;
      beat_ff <= 1'b0;
      unpriv_ff <= 1'b0;
      size_ff <= size_word;
      list_ff <= RESET_LIST;
      rt_ff <= '0;
      rt2_ff <= '0;
      base_idx_ff <= '0;
      addr_ff <= RESET_WORD;
      last_addr_ff <= RESET_WORD;
    end else begin
      case (state_ff)
        st_idle: begin
          if (cmd_fire) begin
            {load_ff, multi_ff, pair_ff, down_ff} <= dec;
            wb_ff <= dec[2] && cmd_writeback;
            beat_ff <= 1'b0;
            // Unprivileged code gets unprivileged accesses on every form
            unpriv_ff <= (!dec[2] && !dec[1] && cmd_form == form_unprivileged) || !cmd_privileged;
            size_ff <= (dec[2] || dec[1]) ? size_word : cmd_size;
            list_ff <= cmd_list;
            rt_ff <= cmd_rt;
            rt2_ff <= cmd_rt2;
            base_idx_ff <= cmd_base_idx;
            addr_ff <= start_addr;
            state_ff <= st_issue;
          end
        end
        st_issue: state_ff <= st_wait;
        st_wait: begin
          if (mem_fire) begin
            last_addr_ff <= addr_ff;
            addr_ff <= nxt_addr;
            list_ff <= nxt_list;
            beat_ff <= 1'b1;
            if (more)
              state_ff <= st_issue;
            else if (wb_ff)
              state_ff <= st_base;
            else
              state_ff <= st_idle;
          end
        end
        st_base: state_ff <= st_idle;
        default: state_ff <= st_idle;
      endcase
    end
  end

  // Memory port; request holds until the memory side accepts it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_req <= 1'b0;
      mem_addr <= RESET_WORD;
      mem_write <= 1'b0;
      mem_size <= size_word;
      mem_unpriv <= 1'b0;
      mem_wdata <= RESET_WORD;
      cur_ff <= '0;
    end else if (state_ff == st_issue) begin
      mem_req <= 1'b1;
      mem_addr <= addr_ff;
      mem_write <= !load_ff;
      mem_size <= size_ff;
      mem_unpriv <= unpriv_ff;
      mem_wdata <= reg_rd_data;
      cur_ff <= cur_idx;
    end else if (mem_fire) begin
      mem_req <= 1'b0;
    end
  end

  load_extend u_extend (
    .raw_data(mem_rdata),
    .size(size_ff),
    .ext_data(ext_data)
  );

  // Register file write, branch and completion pulses
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rf_we <= 1'b0;
      rf_idx <= '0;
      rf_data <= RESET_WORD;
      branch_valid <= 1'b0;
      branch_target <= RESET_WORD;
      done <= 1'b0;
      cmd_error <= 1'b0;
    end else begin
      rf_we <= 1'b0;
      branch_valid <= 1'b0;
      done <= 1'b0;
      cmd_error <= cmd_valid && cmd_ready && bad_offset;
      if (state_ff == st_wait && mem_fire) begin
        done <= !more && !wb_ff;
        if (load_ff && cur_ff == PC_IDX) begin
          branch_valid <= 1'b1;
          branch_target <= {ext_data[WORD_W-1:1], 1'b0};
        end else if (load_ff) begin
          rf_we <= 1'b1;
          rf_idx <= cur_ff;
          rf_data <= ext_data;
        end
      end else if (state_ff == st_base) begin
        rf_we <= 1'b1;
        rf_idx <= base_idx_ff;
        rf_data <= last_addr_ff;
        done <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  single_addr_a: assert property (cmd_fire && !dec[2] |-> ##2 mem_addr == $past(start_addr, 2))
    else $error("first transfer address wrong");
  sign_ext_a: assert property (rf_we && state_ff == st_idle && size_ff == signed_byte_size
    |-> rf_data[31:8] == {24{rf_data[7]}})
    else $error("signed byte not sign extended");
  branch_align_a: assert property (branch_valid |-> branch_target[0] == 1'b0 && !rf_we)
    else $error("branch target not halfword aligned");
  unpriv_a: assert property (cmd_fire && !cmd_privileged |-> ##2 mem_unpriv)
    else $error("unprivileged caller got privileged access");
  ia_step_a: assert property (mem_fire && multi_ff && !down_ff && more
    |-> ##2 mem_req && mem_addr == $past(mem_addr, 2) + WORD_STEP)
    else $error("increment-after step wrong");
  db_step_a: assert property (mem_fire && multi_ff && down_ff && more
    |-> ##2 mem_req && mem_addr == $past(mem_addr, 2) - WORD_STEP)
    else $error("decrement-before step wrong");
  wb_base_a: assert property (mem_fire && !more && wb_ff
    |-> ##2 rf_we && rf_idx == base_idx_ff && rf_data == $past(mem_addr, 2))
    else $error("writeback address wrong");
  pair_range_a: assert property (cmd_valid && cmd_ready && dec[1] && cmd_imm[1:0] != 2'b00
    |=> cmd_error && state_ff == st_idle)
    else $error("misaligned pair offset not refused");
  multi_word_a: assert property (mem_req && multi_ff |-> mem_size == size_word)
    else $error("multiple transfer not word sized");

  ldm_wb_c: cover property (state_ff == st_base && load_ff);
  stm_db_c: cover property (mem_fire && multi_ff && down_ff && !load_ff);
  branch_c: cover property (branch_valid && multi_ff);
  pair_c: cover property (mem_fire && pair_ff && beat_ff);
endmodule // load_store_address_unit

// [core/lsu_pkg.sv]
// Shared constants and types for the load/store address unit
package lsu_pkg;
  localparam int WORD_W = 32;
  localparam int IDX_W = 4;
  localparam int NUM_REGS = 16;
  localparam logic [3:0] SP_IDX = 4'hD;
  localparam logic [3:0] LR_IDX = 4'hE;
  localparam logic [3:0] PC_IDX = 4'hF;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam int IMM_W = 13;
  localparam logic signed [12:0] PCREL_MAX = 13'sd4095;
  localparam logic signed [12:0] PAIR_MAX = 13'sd1020;
  localparam int UNPRIV_IMM_W = 8;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [15:0] RESET_LIST = 16'h0000;

  typedef enum logic [3:0] {
    load_single,
    store_single,
    load_pair,
    load_multiple,
    store_multiple,
    load_multiple_full_descending_alias,
    load_multiple_empty_ascending_alias,
    store_multiple_empty_ascending_alias,
    store_multiple_full_descending_alias
  } lsu_op_e;

  typedef enum logic [1:0] {
    form_register_offset,
    form_unprivileged,
    form_pc_relative
  } addr_form_e;

  typedef enum logic [1:0] {
    mode_default,
    increment_after,
    decrement_before
  } addr_mode_e;

  typedef enum logic [2:0] {
    size_word,
    size_byte,
    size_half,
    signed_byte_size,
    signed_halfword_size
  } size_e;
endpackage

// [tb/lsu_mem_model.sv]
// Data memory and register file read model facing the load/store unit
`timescale 1ns/1ps
module lsu_mem_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] lag,
  input wire logic mem_req,
  output logic mem_ready,
  input wire logic [31:0] mem_addr,
  output logic [31:0] mem_rdata,
  input wire logic [3:0] reg_rd_idx,
  output logic [31:0] reg_rd_data
);
  logic [1:0] wait_ff;
  logic [31:0] junk_ff;
  // Register contents are the index repeated, so store data is predictable
  assign reg_rd_data = {8{reg_rd_idx}};
  // Read data only valid in the accept cycle; a moving pattern otherwise
  assign mem_rdata = mem_ready ? ~mem_addr : junk_ff;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_ready <= 1'b0;
      wait_ff <= 2'h0;
      junk_ff <= 32'h0;
    end else begin
      junk_ff <= junk_ff + 32'h9E37_79B9;
      if (mem_ready || !mem_req) begin
        mem_ready <= 1'b0;
        wait_ff <= 2'h0;
      end else if (wait_ff == lag) begin
        mem_ready <= 1'b1;
      end else begin
        wait_ff <= wait_ff + 2'h1;
      end
    end
  end
endmodule // lsu_mem_model

// [tb/test_load_store_address_unit.sv]
// Self-checking bench for the load/store address unit
`timescale 1ns/1ps
module test_load_store_address_unit;
  import lsu_pkg::*;
  logic clock, cmd_ready, cmd_error, mem_req, mem_ready, mem_write, mem_unpriv, rf_we, branch_valid, flags_we, done;
  logic rst = 1'b1, cmd_valid = 1'b0, cmd_writeback = 1'b0, cmd_privileged = 1'b1, pv = 1'b1, bad;
  lsu_op_e cmd_op = load_single;
  addr_form_e cmd_form = form_register_offset;
  addr_mode_e cmd_mode = mode_default;
  size_e cmd_size = size_word, mem_size;
  logic [3:0] cmd_base_idx = 4'hB, cmd_rt = 4'h2, cmd_rt2 = 4'h3, reg_rd_idx, rf_idx, rt;
  logic [31:0] cmd_base_value = 32'h0, cmd_offset_value = 32'h0, cmd_pc_value = 32'h0, a, b, o;
  logic [31:0] reg_rd_data, mem_addr, mem_wdata, mem_rdata, rf_data, branch_target;
  logic [1:0] cmd_shift = 2'h0, lag = 2'h0, sh = 2'h0, lg = 2'h0;
  logic signed [12:0] cmd_imm = 13'h0;
  logic [15:0] cmd_list = 16'h0001;
  logic [75:0] exp_q[$];
  int miscompares = 0, n_tests = 0, i;
  int tbl[7] = '{4095, -4095, -4096, 1020, -1020, 1022, 1024};

  load_store_address_unit u_load_store_address_unit (
    .clock, .rst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_form, .cmd_mode, .cmd_size, .cmd_writeback,
    .cmd_privileged, .cmd_base_idx, .cmd_base_value, .cmd_offset_value, .cmd_shift, .cmd_imm,
    .cmd_pc_value, .cmd_rt, .cmd_rt2, .cmd_list, .cmd_error, .reg_rd_idx, .reg_rd_data, .mem_req,
    .mem_ready, .mem_addr, .mem_write, .mem_size, .mem_unpriv, .mem_wdata, .mem_rdata, .rf_we,
    .rf_idx, .rf_data, .branch_valid, .branch_target, .flags_we, .done
  );
  lsu_mem_model u_lsu_mem_model (
    .clock, .rst, .lag, .mem_req, .mem_ready, .mem_addr, .mem_rdata, .reg_rd_idx, .reg_rd_data
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic cmp(logic [75:0] got, logic [75:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Empty queue means an event nobody asked for
  task automatic chk(logic [75:0] got);
    if (exp_q.size() == 0) cmp(got, 76'h0);
    else cmp(got, exp_q.pop_front());
  endtask

  function automatic void ex(logic [3:0] k, logic [35:0] h, logic [35:0] l);
    exp_q.push_back({k, h, l});
  endfunction

  function automatic logic [31:0] ext(logic [31:0] d, size_e s);
    case (s)
      size_byte: return {24'h0, d[7:0]};
      size_half: return {16'h0, d[15:0]};
      signed_byte_size: return {{24{d[7]}}, d[7:0]};
      signed_halfword_size: return {{16{d[15]}}, d[15:0]};
      default: return d;
    endcase
  endfunction

  // Result watcher: fixed order within one edge keeps the queue order simple
  always @(posedge clock) begin
    if (mem_req === 1'b1 && mem_ready === 1'b1)
      chk({4'h1, 1'b0, mem_size, mem_addr, 2'h0, (mem_write && mem_size == size_word) ? mem_wdata : 32'h0,
           mem_write, mem_unpriv});
    if (rf_we === 1'b1) chk({4'h2, 32'h0, rf_idx, 4'h0, rf_data});
    if (branch_valid === 1'b1) chk({4'h3, 40'h0, branch_target});
    if (cmd_error === 1'b1) chk({4'h4, 72'h0});
    if (done === 1'b1) chk({4'h5, 71'h0, flags_we});
  end

  task automatic go();
    cmd_valid <= 1'b1;
    @(posedge clock);
    cmd_valid <= 1'b0;
    // Refusal pulse is launched by this edge; look once it has settled
    #1;
    for (i = 0; i < 300 && done !== 1'b1 && cmd_error !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    if (i == 300) begin
      miscompares++;
      complete_run();
    end
  endtask

  task automatic single(lsu_op_e op, addr_form_e f, size_e s, logic [3:0] r, logic [31:0] bv, ov, logic e);
    if (e) ex(4'h4, 36'h0, 36'h0);
    else ex(4'h5, 36'h0, 36'h0);
    @(posedge clock);
    cmd_op <= op;
    cmd_form <= f;
    cmd_size <= s;
    cmd_rt <= r;
    cmd_base_value <= bv;
    cmd_pc_value <= bv;
    cmd_offset_value <= ov;
    cmd_imm <= ov[12:0];
    cmd_shift <= sh;
    cmd_privileged <= pv;
    lag <= lg;
    go();
  endtask

  task automatic multi(lsu_op_e op, addr_mode_e m, logic [15:0] l, logic [31:0] bv, logic wb);
    logic [31:0] ad;
    logic ld, up;
    int r;
    ad = bv;
    ld = op inside {load_multiple, load_multiple_full_descending_alias, load_multiple_empty_ascending_alias};
    up = (op inside {load_multiple, store_multiple}) ? m != decrement_before
       : op inside {load_multiple_full_descending_alias, store_multiple_empty_ascending_alias};
    for (int k = 0; k < 16; k++) begin
      r = up ? k : 15 - k;
      if (l[r]) begin
        ex(4'h1, {1'b0, size_word, ad}, {2'h0, (ld ? 32'h0 : {8{4'(r)}}), !ld, !pv});
        if (ld && r == 15) ex(4'h3, 36'h0, {4'h0, ~ad & 32'hFFFF_FFFE});
        else if (ld) ex(4'h2, {32'h0, 4'(r)}, {4'h0, ~ad});
        ad = up ? ad + 32'h4 : ad - 32'h4;
      end
    end
    if (wb) ex(4'h2, {32'h0, 4'hB}, {4'h0, up ? ad - 32'h4 : ad + 32'h4});
    ex(4'h5, 36'h0, 36'h0);
    @(posedge clock);
    cmd_op <= op;
    cmd_mode <= m;
    cmd_list <= l;
    cmd_base_value <= bv;
    cmd_writeback <= wb;
    lag <= lg;
    go();
  endtask

  initial begin
    void'($urandom(12));
    repeat (20) @(posedge clock);
    cmp({70'h0, mem_req, rf_we, branch_valid, done, cmd_error, cmd_ready}, 76'h1);
    rst <= 1'b0;
    for (int s = 0; s < 5; s++) begin
      for (int w = 0; w < 2; w++) begin
        if (w == 1 && s > 2) continue;
        b = $urandom;
        o = $urandom;
        sh = 2'($urandom);
        rt = 4'($urandom % 13);
        a = b + (o << sh);
        ex(4'h1, {1'b0, size_e'(s), a}, {2'h0, ((w == 1 && s == 0) ? {8{rt}} : 32'h0), w[0], 1'b0});
        if (w == 0) ex(4'h2, {32'h0, rt}, {4'h0, ext(~a, size_e'(s))});
        single(w[0] ? store_single : load_single, form_register_offset, size_e'(s), rt, b, o, 1'b0);
      end
    end
    sh = 2'h2;
    ex(4'h1, {1'b0, size_word, 32'h2000_0200}, 36'h0);
    ex(4'h3, 36'h0, {4'h0, 32'hDFFF_FDFE});
    single(load_single, form_register_offset, size_word, 4'hF, 32'h2000_0100, 32'h40, 1'b0);
    $display("register offset test done");
    for (int k = 0; k < 5; k++) begin
      pv = k[1];
      b = $urandom;
      o = k[0] ? 32'hFF : 32'h0;
      a = b + o;
      ex(4'h1, {1'b0, size_word, a}, 36'h1);
      ex(4'h2, {32'h0, 4'h3}, {4'h0, ~a});
      single(load_single, k < 4 ? form_unprivileged : form_register_offset, size_word, 4'h3, b, o, 1'b0);
    end
    pv = 1'b1;
    $display("unprivileged test done");
    for (int k = 0; k < 7; k++) begin
      b = 32'h1000_2000;
      o = 32'(tbl[k]);
      a = b + o;
      bad = k == 2 || k > 4;
      if (!bad) ex(4'h1, {1'b0, size_word, a}, 36'h0);
      if (!bad) ex(4'h2, {32'h0, 4'h2}, {4'h0, ~a});
      if (!bad && k > 2) ex(4'h1, {1'b0, size_word, a + 32'h4}, 36'h0);
      if (!bad && k > 2) ex(4'h2, {32'h0, 4'h3}, {4'h0, ~(a + 32'h4)});
      single(k > 2 ? load_pair : load_single, form_pc_relative, size_word, 4'h2, b, o, bad);
    end
    $display("pc relative test done");
    for (int k = 3; k < 9; k++) begin
      for (int m = 0; m < 3; m++) begin
        if (m > 0 && k > 4) continue;
        lg = 2'(k % 3);
        // Load lists carry the program counter but never the link register
        multi(lsu_op_e'(k), addr_mode_e'(m), k inside {3, 5, 6} ? 16'h8205 : 16'h1205, 32'h4000_0100,
              1'((k + m) % 2));
      end
    end
    lg = 2'h1;
    multi(load_multiple, increment_after, 16'h0007, 32'hFFFF_FFF8, 1'b1);
    multi(store_multiple, decrement_before, 16'h0007, 32'h0000_0004, 1'b1);
    $display("multiple transfer test done");
    repeat (5) @(posedge clock);
    cmp(76'(exp_q.size()), 76'h0);
    complete_run();
  end
endmodule // test_load_store_address_unit
